// ===== bsp_defs.svh
// constants for the burst-of-four sram port and its controller
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH

// organisation defaults (36-bit wide part)
`define BSP_DATA_W        36
`define BSP_ADDR_W        19
`define BSP_MEM_AW        21

// words per burst and lane widths for write masking
`define BSP_BURST_LEN     4
`define BSP_NIBBLE_W      4
`define BSP_LANE_W        9
`define BSP_SEL_W_NARROW  2

// internal burst counter start for the 8/9-bit parts
`define BSP_BURST_START   2'h0

// phase counter loads: device skips one edge, capture skips two, then four data edges
`define BSP_DEV_PH_START  3'h5
`define BSP_CAP_PH_START  3'h6
`define BSP_PH_LAST       3'h1

// link clock half period in system clocks (controller divider)
`define BSP_LINK_HALF_CYC 6

`endif

// ===== bsp_pkg.sv
// types shared by the sram port and its controller
package bsp_pkg;

    // controller sequencing
    typedef enum logic [1:0] {
        CTRL_IDLE,
        CTRL_CMD,
        CTRL_DATA
    } bsp_ctrl_state_t;

    // two-bit linear burst counter
    typedef logic [1:0] bsp_burst_cnt_t;

endpackage : bsp_pkg

// ===== bsp_if.sv
// link between the memory controller and the burst sram port
`timescale 1ns/10ps

interface bsp_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 19,
    parameter int SEL_W  = 4
);
    // clocks made by the controller
    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    // command
    logic              load_strobe_n;
    logic              read_not_write;
    logic [ADDR_W-1:0] addr;
    logic [SEL_W-1:0]  write_sel_n;
    // shared data bus, one enable per driver
    logic [DATA_W-1:0] dq_ctrl;
    logic              dq_ctrl_oe;
    logic [DATA_W-1:0] dq_dev;
    logic              dq_dev_oe;
    logic [DATA_W-1:0] dq;

    // resolved bus level; undriven bus reads as zero
    assign dq = dq_dev_oe ? dq_dev : (dq_ctrl_oe ? dq_ctrl : '0);

    modport dev (
        input  k, k_n, c, c_n, load_strobe_n, read_not_write, addr,
        input  write_sel_n, dq,
        output dq_dev, dq_dev_oe
    );

    modport ctrl (
        output k, k_n, c, c_n, load_strobe_n, read_not_write, addr,
        output write_sel_n, dq_ctrl, dq_ctrl_oe,
        input  dq
    );

endinterface : bsp_if

// ===== bsp_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps

module bsp_sync #(
    parameter int WIDTH = 1
) (
    // system
    input  wire logic             clock,
    input  wire logic             reset_n,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;

    // first stage feeds only the second stage
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
        end
    end

    assign dout = s2_r;

endmodule : bsp_sync

// ===== bsp_dev.sv
// burst-of-four sram port: device end of the link
`timescale 1ns/10ps
`include "bsp_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1 - controller loads cycles with low strobe
// RULE2 - every transfer is four words, two periods
// RULE3 - nibble selects sampled with their write data
// RULE4 - nibble select 0 low nibble, 1 high
// RULE5 - deselected nibble keeps its stored value
// RULE6 - byte selects sampled with their write data
// RULE7 - byte select n gates nine-bit lane n
// RULE8 - deselected byte lane keeps stored value
// RULE9 - one address bus, captured with strobe
// RULE10 - narrow parts start burst counter at zero
// RULE11 - wide parts seed counter from low bits
// RULE12 - direction high reads, low writes
// RULE13 - read data launched on output clock pair
// RULE14 - commands captured on main clock rise
// RULE15 - complementary clock captures second write word
// RULE16 - single clock mode uses input clock pair
// RULE17 - data outputs released when not reading
// RULE18 - one read word per output clock rise
// RULE19 - no new load before burst issued
module bsp_dev #(
    parameter int DATA_W = `BSP_DATA_W,
    parameter int ADDR_W = `BSP_ADDR_W,
    parameter int MEM_AW = `BSP_MEM_AW
) (
    // system
    input  wire logic clock,
    input  wire logic reset_n,
    // link to the controller
    bsp_if.dev        link,
    // strap and status
    input  wire logic single_clock_mode,
    output logic      burst_active
);

    localparam bit NARROW = (DATA_W == 8) || (DATA_W == 9);
    localparam int SEL_W  = (DATA_W == 8) ? `BSP_SEL_W_NARROW
                                          : DATA_W / `BSP_LANE_W;
    localparam int LANE_W = (DATA_W == 8) ? `BSP_NIBBLE_W : `BSP_LANE_W;
    localparam int INT_AW = NARROW ? ADDR_W + 2 : ADDR_W;
    localparam int IDX_W  = (MEM_AW < INT_AW) ? MEM_AW : INT_AW;
    localparam int BASE_W = INT_AW - 2;
    localparam int SYNC_W = 7 + ADDR_W + SEL_W + DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [SYNC_W-1:0] sync_out;
    logic [DATA_W-1:0] dq_s;
    logic [3:0]        clk_s;
    logic              ld_n_s;
    logic              rw_s;
    logic [ADDR_W-1:0] addr_s;
    logic [SEL_W-1:0]  sel_n_s;
    logic              single_s;

    // every pin, clocks included, goes through two flops
    bsp_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .din     ({single_clock_mode, link.write_sel_n, link.addr,
                   link.read_not_write, link.load_strobe_n,
                   link.c_n, link.c, link.k_n, link.k, link.dq}),
        .dout    (sync_out)
    );

    // unpack; clocks and data share the same delay
    assign {single_s, sel_n_s, addr_s, rw_s, ld_n_s, clk_s, dq_s} =
        sync_out;

    ////////////////////////////////////////////////////////////////////////
    // link clock edges

    logic [3:0] clk_prev_r;
    logic [3:0] clk_rise;
    logic       k_rise;
    logic       kn_rise;
    logic       out_edge;
    logic       cmd;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clk_prev_r <= 4'h0;
        end else begin
            clk_prev_r <= clk_s;
        end
    end

    assign clk_rise = clk_s & ~clk_prev_r;
    assign k_rise   = clk_rise[0];
    assign kn_rise  = clk_rise[1];
    // read launch clocks: output pair, or input pair in single mode
    assign out_edge = single_s ? (clk_rise[0] | clk_rise[1])  // [RULE16]
                               : (clk_rise[2] | clk_rise[3]); // [RULE13]
    // a cycle starts only on a main clock rise with strobe low
    assign cmd      = k_rise & ~ld_n_s;                   // [RULE1] [RULE14]

    ////////////////////////////////////////////////////////////////////////
    // command address and burst counter seed

    logic [INT_AW-1:0] cmd_addr;

    generate
        if (NARROW) begin : g_narrow
            // low two bits are internal and always start at zero
            assign cmd_addr = {addr_s, `BSP_BURST_START};      // [RULE10]
        end else begin : g_wide
            // burst_low_bit1/burst_low_bit0 seed the counter
            assign cmd_addr = addr_s;                          // [RULE11]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // storage and write masking

    logic [DATA_W-1:0]      mem [2**IDX_W];
    logic [2:0]             wr_ph_r;
    logic [BASE_W-1:0]      wr_base_r;
    bsp_pkg::bsp_burst_cnt_t wr_cnt_r;
    logic [INT_AW-1:0]      wr_full;
    logic [IDX_W-1:0]       wr_idx;
    logic [DATA_W-1:0]      wr_old;
    logic [DATA_W-1:0]      wr_merge;
    logic                   wr_fire;
    logic [DATA_W-1:0]      wr_dq_r;
    logic [SEL_W-1:0]       wr_sel_n_r;

    // data as it stood one clock before the synced edge: the controller
    // moves data with its clocks, so the edge view already shows the next
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_dq_r    <= '0;
            wr_sel_n_r <= '1;
        end else begin
            wr_dq_r    <= dq_s;
            wr_sel_n_r <= sel_n_s;
        end
    end

    assign wr_full = {wr_base_r, wr_cnt_r};
    assign wr_idx  = wr_full[IDX_W-1:0];
    assign wr_old  = mem[wr_idx];

    // per lane: select low takes the bus, high keeps the old value
    genvar g;
    generate
        for (g = 0; g < SEL_W; g++) begin : g_lane
            assign wr_merge[g*LANE_W +: LANE_W] =
                wr_sel_n_r[g] ? wr_old[g*LANE_W +: LANE_W] // [RULE5] [RULE8]
                              : wr_dq_r[g*LANE_W +: LANE_W]; // [RULE4] [RULE7]
        end
    endgenerate

    // data and selects sampled on both k and k_n rises; the first
    // edge after the command only skips, words land on the next four
    assign wr_fire = (k_rise | kn_rise) &&                // [RULE3] [RULE6]
                     (wr_ph_r != 3'h0) &&
                     (wr_ph_r != `BSP_DEV_PH_START);      // [RULE15]

    // write sequencing: address captured with the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ph_r   <= 3'h0;
            wr_base_r <= '0;
            wr_cnt_r  <= 2'h0;
        end else if (cmd && !rw_s) begin                  // [RULE12]
            wr_ph_r   <= `BSP_DEV_PH_START;               // [RULE2]
            wr_base_r <= cmd_addr[INT_AW-1:2];            // [RULE9]
            wr_cnt_r  <= cmd_addr[1:0];
        end else if ((k_rise | kn_rise) && wr_ph_r != 3'h0) begin
            wr_ph_r <= wr_ph_r - 3'h1;
            if (wr_fire) begin
                wr_cnt_r <= wr_cnt_r + 2'h1;              // [RULE11]
            end
        end
    end

    // array write, no reset on storage
    always_ff @(posedge clock) begin
        if (wr_fire) begin
            mem[wr_idx] <= wr_merge;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read sequencing and output drive

    logic [2:0]              rd_ph_r;
    logic [BASE_W-1:0]       rd_base_r;
    bsp_pkg::bsp_burst_cnt_t rd_cnt_r;
    logic [INT_AW-1:0]       rd_full;
    logic [DATA_W-1:0]       dq_r;
    logic                    oe_r;
    logic                    rd_word;

    assign rd_full = {rd_base_r, rd_cnt_r};
    assign rd_word = out_edge && (rd_ph_r != 3'h0) &&
                     (rd_ph_r != `BSP_DEV_PH_START);

    // read command load and per-word counter advance
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_ph_r   <= 3'h0;
            rd_base_r <= '0;
            rd_cnt_r  <= 2'h0;
        end else if (cmd && rw_s) begin                   // [RULE12]
            rd_ph_r   <= `BSP_DEV_PH_START;               // [RULE2]
            rd_base_r <= cmd_addr[INT_AW-1:2];            // [RULE9]
            rd_cnt_r  <= cmd_addr[1:0];
        end else if (out_edge && rd_ph_r != 3'h0) begin
            rd_ph_r <= rd_ph_r - 3'h1;
            if (rd_word) begin
                rd_cnt_r <= rd_cnt_r + 2'h1;              // [RULE11]
            end
        end
    end

    // one word per launch edge; bus released on the edge after the last
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dq_r <= '0;
            oe_r <= 1'b0;
        end else if (rd_word) begin
            dq_r <= mem[rd_full[IDX_W-1:0]];              // [RULE18]
            oe_r <= 1'b1;
        end else if (out_edge && rd_ph_r == 3'h0) begin
            oe_r <= 1'b0;                                 // [RULE17]
        end
    end

    // status: a burst is in flight in either direction
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            burst_active <= 1'b0;
        end else begin
            burst_active <= (wr_ph_r != 3'h0) || (rd_ph_r != 3'h0);
        end
    end

    assign link.dq_dev    = dq_r;
    assign link.dq_dev_oe = oe_r;

endmodule : bsp_dev

// ===== bsp_ctrl.sv
// burst-of-four sram port: controller end of the link
`timescale 1ns/10ps
`include "bsp_defs.svh"

module bsp_ctrl #(
    parameter int DATA_W   = `BSP_DATA_W,
    parameter int ADDR_W   = `BSP_ADDR_W,
    parameter int HALF_CYC = `BSP_LINK_HALF_CYC,
    parameter int SEL_W    = (DATA_W == 8) ? `BSP_SEL_W_NARROW
                                           : DATA_W / `BSP_LANE_W
) (
    // system
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    // link to the device
    bsp_if.ctrl                             link,
    // request
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire logic                       req_read,
    input  wire logic [ADDR_W-1:0]          req_addr,
    input  wire logic [4*DATA_W-1:0]        req_wdata,
    input  wire logic [4*SEL_W-1:0]         req_wsel_n,
    // read answer
    output logic                            rd_valid,
    output logic [4*DATA_W-1:0]             rd_data
);

    ////////////////////////////////////////////////////////////////////////
    // link clock divider: k and c run together, c_n/k_n inverted

    logic [7:0] div_r;
    logic       k_r;
    logic       tick;
    logic       fall_tick;
    logic       rise_tick;

    assign tick      = (div_r == 8'(HALF_CYC - 1));
    assign fall_tick = tick & k_r;
    assign rise_tick = tick & ~k_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 8'h00;
            k_r   <= 1'b0;
        end else if (tick) begin
            div_r <= 8'h00;
            k_r   <= ~k_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    logic kn_r;
    logic c_r;
    logic cn_r;

    // separate flops so every link clock leaves from a register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            kn_r <= 1'b1;
            c_r  <= 1'b0;
            cn_r <= 1'b1;
        end else if (tick) begin
            kn_r <= k_r;
            c_r  <= ~k_r;
            cn_r <= k_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command and write data sequencing

    bsp_pkg::bsp_ctrl_state_t st_r;
    logic                     ld_n_r;
    logic                     rw_r;
    logic [ADDR_W-1:0]        addr_r;
    logic [4*DATA_W-1:0]      wdata_r;
    logic [4*SEL_W-1:0]       wsel_r;
    logic [SEL_W-1:0]         sel_r;
    logic [DATA_W-1:0]        dq_r;
    logic                     oe_r;
    logic [1:0]               slot_r;
    logic                     acc;

    // commands go out on a k fall so they are settled at the k rise
    assign acc = fall_tick & req_ready & req_valid; // [RULE19]

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r      <= bsp_pkg::CTRL_IDLE;
            req_ready <= 1'b1;
            ld_n_r    <= 1'b1;
            rw_r      <= 1'b1;
            addr_r    <= '0;
            wdata_r   <= '0;
            wsel_r    <= '1;
            sel_r     <= '1;
            dq_r      <= '0;
            oe_r      <= 1'b0;
            slot_r    <= 2'h0;
        end else begin
            case (st_r)
                bsp_pkg::CTRL_CMD: begin
                    if (fall_tick) begin
                        ld_n_r <= 1'b1;
                        slot_r <= 2'h0;
                        st_r   <= bsp_pkg::CTRL_DATA;
                        if (!rw_r) begin
                            oe_r  <= 1'b1;
                            dq_r  <= wdata_r[0 +: DATA_W];
                            sel_r <= wsel_r[0 +: SEL_W];
                        end
                    end
                end
                bsp_pkg::CTRL_DATA: begin
                    if (tick && slot_r != 2'h3) begin
                        slot_r <= slot_r + 2'h1;
                        dq_r   <= wdata_r[(slot_r + 2'h1)*DATA_W +: DATA_W];
                        if (!rw_r) begin
                            sel_r <= wsel_r[(slot_r + 2'h1)*SEL_W +: SEL_W];
                        end
                        // open for the next command as the last word goes out, one half period before the burst's end
                        if (slot_r == 2'h2) begin
                            req_ready <= 1'b1;
                        end
                    end else if (tick) begin
                        oe_r  <= 1'b0;
                        sel_r <= '1;
                        st_r  <= bsp_pkg::CTRL_IDLE;
                    end
                end
                default: begin
                end
            endcase
            // new load only once the last burst is issued
            if (acc) begin
                req_ready <= 1'b0;
                ld_n_r    <= 1'b0;
                rw_r      <= req_read;
                addr_r    <= req_addr;
                wdata_r   <= req_wdata;
                wsel_r    <= req_wsel_n;
                st_r      <= bsp_pkg::CTRL_CMD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read capture, one half period after each launch edge

    logic [DATA_W-1:0] dq_s;
    logic [2:0]        cap_r;
    logic              cap_hit;

    bsp_sync #(
        .WIDTH (DATA_W)
    ) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .din     (link.dq),
        .dout    (dq_s)
    );

    // words sit on the bus from the second edge after the command's k rise
    assign cap_hit = tick && (cap_r != 3'h0) && (cap_r <= 3'h4);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cap_r    <= 3'h0;
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= cap_hit && (cap_r == `BSP_PH_LAST);
            if (cap_hit) begin
                rd_data[2'(3'h4 - cap_r)*DATA_W +: DATA_W] <= dq_s;
            end
            if (rise_tick && st_r == bsp_pkg::CTRL_CMD && rw_r) begin
                cap_r <= `BSP_CAP_PH_START;
            end else if (tick && cap_r != 3'h0) begin
                cap_r <= cap_r - 3'h1;
            end
        end
    end

    assign link.k              = k_r;
    assign link.k_n            = kn_r;
    assign link.c              = c_r;
    assign link.c_n            = cn_r;
    assign link.load_strobe_n  = ld_n_r;
    assign link.read_not_write = rw_r;
    assign link.addr           = addr_r;
    assign link.write_sel_n    = sel_r;
    assign link.dq_ctrl        = dq_r;
    assign link.dq_ctrl_oe     = oe_r;

endmodule : bsp_ctrl

// ===== bsp_assertions.sv
// concurrent checks on the link between controller and sram port
`timescale 1ns/10ps

module bsp_chk #(
    parameter int SEL_W    = 4,
    parameter int HALF_CYC = 6
) (
    // system
    input  wire logic             clock,
    input  wire logic             reset_n,
    // link
    input  wire logic             k,
    input  wire logic             load_strobe_n,
    input  wire logic             read_not_write,
    input  wire logic [SEL_W-1:0] write_sel_n,
    input  wire logic             dq_ctrl_oe,
    input  wire logic             dq_dev_oe
);
    logic [7:0] wr_cnt_r;
    logic [7:0] rd_cnt_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // cycles each driver has held the bus; a counter keeps repetitions short
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_cnt_r <= 8'h00;
        end else begin
            wr_cnt_r <= dq_ctrl_oe ? wr_cnt_r + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_cnt_r <= 8'h00;
        end else begin
            rd_cnt_r <= dq_dev_oe ? rd_cnt_r + 8'h01 : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_cmd_k;
        $fell(load_strobe_n) |-> !k ##[1:8] $rose(k);
    endproperty
    a_cmd_k: assert property (p_cmd_k)
        else $error("no main clock rise after load");
    property p_load_len;
        $fell(load_strobe_n) |=> !load_strobe_n [*8];
    endproperty
    a_load_len: assert property (p_load_len)
        else $error("load strobe too short");
    property p_k_half;
        $rose(k) |-> k [*6] ##1 !k;
    endproperty
    a_k_half: assert property (p_k_half)
        else $error("link clock half period wrong");
    property p_dev_read;
        $rose(dq_dev_oe) |-> read_not_write;
    endproperty
    a_dev_read: assert property (p_dev_read)
        else $error("device drives bus outside a read");
    property p_one_driver;
        !(dq_dev_oe && dq_ctrl_oe);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the bus");
    property p_wr_len;
        $fell(dq_ctrl_oe) |-> wr_cnt_r == 4 * HALF_CYC;
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("write burst length wrong");
    property p_rd_len;
        $fell(dq_dev_oe) |-> rd_cnt_r == 4 * HALF_CYC;
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read burst length wrong");
    property p_sel_idle;
        !dq_ctrl_oe |-> &write_sel_n;
    endproperty
    a_sel_idle: assert property (p_sel_idle)
        else $error("write selects active outside write data");
    property p_wr_dir;
        $rose(dq_ctrl_oe) |-> !read_not_write && load_strobe_n;
    endproperty
    a_wr_dir: assert property (p_wr_dir)
        else $error("write data without write command");

    // main scenarios reached
    c_read:  cover property ($rose(dq_dev_oe));
    c_write: cover property ($rose(dq_ctrl_oe));
    c_rdcmd: cover property ($fell(load_strobe_n) ##1 read_not_write);
endmodule : bsp_chk

// ===== tb.sv
// self-checking bench: controller and sram port joined by the link
`timescale 1ns/10ps

module tb;
    logic         clock;
    logic         reset_n;
    logic         scm;
    logic         req_valid;
    logic         req_ready;
    logic         req_read;
    logic [18:0]  req_addr;
    logic [143:0] req_wdata;
    logic [15:0]  req_wsel_n;
    logic         rd_valid;
    logic         busy;
    logic [143:0] rd_data;
    logic [35:0]  ref_m [0:63];
    int           errors;
    int           n_compared;

    ////////////////////////////////////////////////////////////////////////
    // small array keeps memory use low; addresses stay below 64
    bsp_if link ();
    bsp_dev #(.MEM_AW(6)) u_bsp_dev (.clock(clock), .reset_n(reset_n),
        .link(link), .single_clock_mode(scm), .burst_active(busy));
    bsp_ctrl u_bsp_ctrl (.clock(clock), .reset_n(reset_n), .link(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
        .req_addr(req_addr), .req_wdata(req_wdata),
        .req_wsel_n(req_wsel_n), .rd_valid(rd_valid), .rd_data(rd_data));
    bsp_chk u_bsp_chk (.clock(clock), .reset_n(reset_n), .k(link.k),
        .load_strobe_n(link.load_strobe_n),
        .read_not_write(link.read_not_write),
        .write_sel_n(link.write_sel_n), .dq_ctrl_oe(link.dq_ctrl_oe),
        .dq_dev_oe(link.dq_dev_oe));

    always #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [143:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // four distinct words, each with the same value in all four lanes
    function automatic logic [143:0] pat(input logic [7:0] k);
        for (int i = 0; i < 4; i++) begin
            pat[i*36+:36] = {4{k ^ 8'(i * 37), i[0]}};
        end
    endfunction : pat

    // one burst; the model follows the counter, wrapping mod four
    task automatic issue(input logic rd, input logic [5:0] a,
                         input logic [143:0] wd, input logic [15:0] ws);
        logic [5:0]   idx;
        logic [143:0] exp;
        for (int i = 0; i < 4; i++) begin
            idx = {a[5:2], a[1:0] + 2'(i)};
            for (int l = 0; l < 4; l++) begin
                if (!rd && !ws[i*4+l]) ref_m[idx][l*9+:9] = wd[i*36+l*9+:9];
            end
            exp[i*36+:36] = ref_m[idx];
        end
        @(posedge clock);
        req_valid  <= 1'b1;
        req_read   <= rd;
        req_addr   <= {13'h0000, a};
        req_wdata  <= wd;
        req_wsel_n <= ws;
        // hold until ready has been seen high and then dropped
        do @(posedge clock); while (req_ready !== 1'b1);
        do @(posedge clock); while (req_ready !== 1'b0);
        req_valid <= 1'b0;
        // mid burst: the port must report itself busy
        repeat (12) @(posedge clock);
        #1;
        chk("burst active", {143'h0, 1'b1}, {143'h0, busy});
        if (rd) begin
            do @(posedge clock); while (rd_valid !== 1'b1);
            #1;
            chk("read burst", exp, rd_data);
        end
    endtask : issue

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clock      = 1'b0;
        reset_n    = 1'b0;
        scm        = 1'b0;
        req_valid  = 1'b0;
        req_read   = 1'b0;
        req_addr   = '0;
        req_wdata  = '0;
        req_wsel_n = '1;
        errors     = 0;
        n_compared = 0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        // full burst written then read back
        issue(1'b0, 6'h08, pat(8'h11), 16'h0000);
        issue(1'b1, 6'h08, '0, 16'hffff);
        // masked lanes keep their contents, mask differs per word
        issue(1'b0, 6'h08, pat(8'h5a), 16'h7e5a);
        issue(1'b1, 6'h08, '0, 16'hffff);
        // every counter seed, read back from another seed
        for (int s = 0; s < 4; s++) begin
            issue(1'b0, 6'h10 | 6'(s), pat(8'(s + 3)), 16'h0000);
            issue(1'b1, 6'h10 | 6'(s ^ 2), '0, 16'hffff);
        end
        // read data launched on the input clock pair
        scm <= 1'b1;
        repeat (4) @(posedge clock);
        issue(1'b1, 6'h08, '0, 16'hffff);
        end_of_test();
    end

    // hang guard, far beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        end_of_test();
    end
endmodule : tb
